// *** logic/qctu_top.sv ***
// Quad cascadable timer unit with interface-unit clock selection
`timescale 1ns/1ps
`default_nettype none
`include "qctu_params.svh"
module qctu_top
  import qctu_pkg::*;
#(
  parameter int NT = 4,
  parameter int TW = `QCTU_TW
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`QCTU_AW-1:0] regAddr,
  input wire logic [`QCTU_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`QCTU_DW-1:0] regRdata,
  input wire logic timerExtInput1,
  input wire logic timerExtInput2,
  input wire logic timerExtInput3,
  input wire logic timerExtInput4,
  input wire logic gateInFirstPair,
  input wire logic gateInSecondPair,
  input wire logic externalClockFive,
  input wire logic dedicatedTimerClockPin,
  output logic [NT-1:0] timerMatchOutput,
  output logic siuTimerTick,
  output logic irq
);

  // ==============================================
  // State
  typedef struct packed {
    qctu_tcfg_t [NT-1:0] cfg;
    logic [NT-1:0][TW-1:0] refv;
    logic [1:0] clkSel;
    logic [15:0] brgDiv;
    logic [15:0] brgCnt;
    logic brgTick;
    logic siuTick;
    logic [3:0] div16;
    logic [`QCTU_NSYNC-1:0] prev;
    logic [2*NT-1:0] istat;
    logic [2*NT-1:0] ien;
    logic [`QCTU_DW-1:0] rdata;
  } qctu_top_st_t;
  qctu_top_st_t st_r, st_nxt;

  logic [`QCTU_NSYNC-1:0] syncd;
  logic [`QCTU_NSYNC-1:0] rise;
  logic [`QCTU_NSYNC-1:0] fall;
  logic div16Tick;
  logic brgIn;
  logic [NT-1:0] srcTick;
  logic [NT-1:0] gateBlock;
  logic [NT-1:0] restart;
  logic [NT-1:0] capture;
  logic [NT-1:0] tmrMatch;
  logic [NT-1:0] tmrOut;
  logic [NT-1:0][TW-1:0] tmrCnt;
  logic [NT-1:0][TW-1:0] tmrCap;
  logic [1:0] tIdx;
  logic [3:0] grp;

  // ==============================================
  // Pin synchronisers
  // Slow external pins; edges seen here assume each level stands two clocks
  qctu_sync #(.W(`QCTU_NSYNC)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn({dedicatedTimerClockPin, externalClockFive, gateInSecondPair, gateInFirstPair,
      timerExtInput4, timerExtInput3, timerExtInput2, timerExtInput1}),
    .pinOut(syncd)
  );

  assign rise = syncd & ~st_r.prev;
  assign fall = ~syncd & st_r.prev;
  assign div16Tick = (st_r.div16 == `QCTU_DIV16_LAST);
  assign tIdx = regAddr[3:2];
  assign grp = regAddr[7:4];

  // ==============================================
  // Timer sources, gates and capture
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      case (st_r.cfg[i].src)
        SRC_CHAIN: begin
          // Previous timer's match drives this count; timer 1 takes timer 4's match
          srcTick[i] = tmrMatch[(i + NT - 1) % NT];
        end
        SRC_SYS: begin
          srcTick[i] = 1'b1;
        end
        SRC_DIV16: begin
          srcTick[i] = div16Tick;
        end
        SRC_PIN: begin
          srcTick[i] = rise[i];
        end
        default: begin
          srcTick[i] = 1'b0;
        end
      endcase
      // Timers 1,2 follow the first gate, 3,4 the second
      gateBlock[i] = st_r.cfg[i].gateEn && !syncd[`QCTU_S_GATE + i / 2];
      restart[i] = st_r.cfg[i].gateEn && st_r.cfg[i].gateRestart
        && rise[`QCTU_S_GATE + i / 2];
      capture[i] = (rise[i] && st_r.cfg[i].capEdge[0])
        || (fall[i] && st_r.cfg[i].capEdge[1]);
    end
  end

  // ==============================================
  // Timers
  generate
    for (genvar g = 0; g < NT; g++) begin : g_tmr
      qctu_timer #(.TW(TW)) u_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .tick(srcTick[g]),
        .run(st_r.cfg[g].run),
        .gateBlock(gateBlock[g]),
        .restart(restart[g]),
        .capture(capture[g]),
        .refVal(st_r.refv[g]),
        .toggleMode(st_r.cfg[g].toggle),
        .outEn(st_r.cfg[g].outEn),
        .cnt(tmrCnt[g]),
        .cap(tmrCap[g]),
        .match(tmrMatch[g]),
        .outLvl(tmrOut[g])
      );
    end
  endgenerate

  // ==============================================
  // Baud generator input and interface-unit clock choice
  assign brgIn = st_r.clkSel[`QCTU_CLKSEL_EXTERNAL_CLOCK_FIVE] ? rise[`QCTU_S_EXTERNAL_CLOCK_FIVE] : 1'b1;

  // ==============================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = syncd;
    st_nxt.div16 = st_r.div16 + 4'h1;
    st_nxt.brgTick = 1'b0;
    if (brgIn) begin
      if (st_r.brgCnt >= st_r.brgDiv) begin
        st_nxt.brgCnt = '0;
        st_nxt.brgTick = 1'b1;
      end else begin
        st_nxt.brgCnt = st_r.brgCnt + 16'h0001;
      end
    end
    // Two sources never both reach the interface-unit timers
    if (st_r.clkSel[`QCTU_CLKSEL_DEDICATED_TIMER_CLOCK_PIN]) begin
      st_nxt.siuTick = rise[`QCTU_S_DEDICATED_TIMER_CLOCK_PIN];
    end else begin
      st_nxt.siuTick = st_r.brgTick;
    end
    // Set wins over a clear in the same cycle
    st_nxt.istat = st_r.istat | {capture, tmrMatch};
    st_nxt.rdata = '0;
    if (regWr) begin
      case (grp)
        `QCTU_G_CFG: begin
          st_nxt.cfg[tIdx] = regWdata[`QCTU_CFG_W-1:0];
        end
        `QCTU_G_REF: begin
          st_nxt.refv[tIdx] = regWdata[TW-1:0];
        end
        default: begin
          case (regAddr)
            `QCTU_A_CLKSEL: st_nxt.clkSel = regWdata[1:0];
            `QCTU_A_BRGDIV: st_nxt.brgDiv = regWdata[15:0];
            `QCTU_A_ICLR: st_nxt.istat = (st_r.istat & ~regWdata[2*NT-1:0])
              | {capture, tmrMatch};
            `QCTU_A_IEN: st_nxt.ien = regWdata[2*NT-1:0];
            default: st_nxt.ien = st_r.ien;
          endcase
        end
      endcase
    end
    if (regRd) begin
      case (grp)
        `QCTU_G_CFG: st_nxt.rdata = {23'h000000, st_r.cfg[tIdx]};
        `QCTU_G_REF: st_nxt.rdata = {16'h0000, st_r.refv[tIdx]};
        `QCTU_G_CNT: st_nxt.rdata = {16'h0000, tmrCnt[tIdx]};
        `QCTU_G_CAP: st_nxt.rdata = {16'h0000, tmrCap[tIdx]};
        default: begin
          case (regAddr)
            `QCTU_A_CLKSEL: st_nxt.rdata = {30'h00000000, st_r.clkSel};
            `QCTU_A_BRGDIV: st_nxt.rdata = {16'h0000, st_r.brgDiv};
            `QCTU_A_ISTAT: st_nxt.rdata = {24'h000000, st_r.istat};
            `QCTU_A_IEN: st_nxt.rdata = {24'h000000, st_r.ien};
            default: st_nxt.rdata = '0;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      for (int i = 0; i < NT; i++) begin
        st_r.cfg[i] <= `QCTU_CFG_RST;
        st_r.refv[i] <= `QCTU_REF_RST;
      end
      st_r.brgDiv <= `QCTU_BRGDIV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==============================================
  // Outputs
  assign regRdata = st_r.rdata;
  assign timerMatchOutput = tmrOut;
  assign siuTimerTick = st_r.siuTick;
  assign irq = |(st_r.istat & st_r.ien);

  // ==============================================
  // Checks
  AST_DIV16: assert property (@(posedge clk) disable iff (!rst_b)
    div16Tick |=> !div16Tick [*8])
    else $error("divide-by-16 tick too early");
  AST_CASCADE: assert property (@(posedge clk) disable iff (!rst_b)
    tmrMatch[0] && st_r.cfg[1].src == SRC_CHAIN && st_r.cfg[1].run
      && !gateBlock[1] && !restart[1] && st_r.refv[1] != 16'h0000
      |=> tmrCnt[1] != $past(tmrCnt[1]))
    else $error("chained timer missed its carry");
  AST_DEDICATED_TIMER_CLOCK_PIN_EXCL: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.clkSel[`QCTU_CLKSEL_DEDICATED_TIMER_CLOCK_PIN] && !rise[`QCTU_S_DEDICATED_TIMER_CLOCK_PIN] |=> !siuTimerTick)
    else $error("baud generator leaked past dedicated clock");
  AST_DEDICATED_TIMER_CLOCK_PIN: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.clkSel[`QCTU_CLKSEL_DEDICATED_TIMER_CLOCK_PIN] && rise[`QCTU_S_DEDICATED_TIMER_CLOCK_PIN] |=> siuTimerTick)
    else $error("dedicated clock edge lost");
  AST_EXTERNAL_CLOCK_FIVE: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.clkSel == 2'h1 && !rise[`QCTU_S_EXTERNAL_CLOCK_FIVE] |=> !st_r.brgTick)
    else $error("baud generator stepped without clock five edge");
  AST_BRG_INT: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.clkSel == 2'h0 && st_r.brgTick |=> siuTimerTick)
    else $error("internal baud tick lost");
  AST_GATE_PAIR: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.cfg[3].gateEn && !syncd[`QCTU_S_GATE + 1] |-> gateBlock[3] && !gateBlock[1] == 1'b1
      || st_r.cfg[1].gateEn)
    else $error("second gate misrouted");
  AST_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
    tmrMatch[0] && st_r.ien[0] |=> irq)
    else $error("match interrupt missed");

  AST_CASCADE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.cfg[1].src == SRC_CHAIN && st_r.cfg[1].run && !tmrMatch[0] && !restart[1]
      |=> tmrCnt[1] == $past(tmrCnt[1]))
    else $error("chained timer moved without carry");

  AST_SRC_SYS: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.cfg[0].run && st_r.cfg[0].src == SRC_SYS && !gateBlock[0] && !restart[0]
      && tmrCnt[0] != st_r.refv[0] |=> tmrCnt[0] == $past(tmrCnt[0]) + 16'h0001)
    else $error("system clock timer did not step");

  AST_SRC_DIV16: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.cfg[1].run && st_r.cfg[1].src == SRC_DIV16 && !div16Tick && !restart[1]
      |=> tmrCnt[1] == $past(tmrCnt[1]))
    else $error("divided timer stepped off its tick");

  AST_SRC_PIN: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.cfg[2].run && st_r.cfg[2].src == SRC_PIN && !rise[2] && !restart[2]
      |=> tmrCnt[2] == $past(tmrCnt[2]))
    else $error("pin timer stepped without an edge");

  AST_DIV16_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
    div16Tick |-> ##16 div16Tick)
    else $error("divide-by-16 period wrong");

  AST_RUN_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    !st_r.cfg[0].run |=> tmrCnt[0] == 16'h0000)
    else $error("stopped timer kept a count");

  AST_OUT_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    !st_r.cfg[0].outEn |=> timerMatchOutput[0])
    else $error("disabled output not high");

  AST_OUT_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    $past(st_r.cfg[0].outEn) && !$past(st_r.cfg[0].toggle)
      |-> timerMatchOutput[0] == !tmrMatch[0])
    else $error("pulse output does not follow match");

  AST_OUT_TOGGLE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    $past(st_r.cfg[0].outEn) && $past(st_r.cfg[0].toggle) && !tmrMatch[0]
      |-> timerMatchOutput[0] == $past(timerMatchOutput[0]))
    else $error("toggle output moved without match");

  AST_CAPEDGE_NONE: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.cfg[0].capEdge == 2'h0 |-> !capture[0])
    else $error("capture with no edge selected");

  AST_CAP_SET: assert property (@(posedge clk) disable iff (!rst_b)
    capture[0] |=> st_r.istat[NT])
    else $error("capture status not set");

  AST_GATE1_T1: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.cfg[0].gateEn && !syncd[`QCTU_S_GATE] |-> gateBlock[0])
    else $error("first gate did not hold timer 1");

  AST_RESTART_SRC: assert property (@(posedge clk) disable iff (!rst_b)
    restart[1] |-> rise[`QCTU_S_GATE])
    else $error("timer 2 restarted without first gate edge");

  AST_GATE_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    !st_r.cfg[2].gateEn |-> !gateBlock[2] && !restart[2])
    else $error("ungated timer 3 held by gate");

  AST_BRG_SYS: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.clkSel == 2'h0 && st_r.brgDiv == 16'h0000 |=> st_r.brgTick)
    else $error("internal baud input missing");

  // ==============================================
  // Register bus and interrupt checks

  AST_RD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(regRd) |-> regRdata == 32'h00000000)
    else $error("read data outside its cycle");

  AST_ISTAT_SET: assert property (@(posedge clk) disable iff (!rst_b)
    tmrMatch[0] |=> st_r.istat[0])
    else $error("match status not set");

  AST_ISTAT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.istat[0] && !(regWr && regAddr == `QCTU_A_ICLR) |=> st_r.istat[0])
    else $error("status bit lost without clear");

  AST_IEN_MASK: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.ien == 8'h00 |-> !irq)
    else $error("masked interrupt raised");
endmodule
`default_nettype wire

// *** logic/qctu_params.svh ***
// Constants for the quad cascadable timer unit
`ifndef QCTU_PARAMS_SVH
`define QCTU_PARAMS_SVH

// ==============================================
// Register bus
`define QCTU_AW 8
`define QCTU_DW 32
`define QCTU_A_CLKSEL 8'h04
`define QCTU_A_BRGDIV 8'h08
`define QCTU_A_ISTAT 8'h50
`define QCTU_A_ICLR 8'h54
`define QCTU_A_IEN 8'h58
// Per-timer groups: address[7:4] group, address[3:2] timer
`define QCTU_G_CFG 4'h1
`define QCTU_G_REF 4'h2
`define QCTU_G_CNT 4'h3
`define QCTU_G_CAP 4'h4

// ==============================================
// Widths and reset values
`define QCTU_TW 16
`define QCTU_CFG_W 9
`define QCTU_CFG_RST 9'h001
`define QCTU_REF_RST 16'hFFFF
`define QCTU_BRGDIV_RST 16'h0000
`define QCTU_DIV16_LAST 4'hF
`define QCTU_CLKSEL_EXTERNAL_CLOCK_FIVE 0
`define QCTU_CLKSEL_DEDICATED_TIMER_CLOCK_PIN 1

// ==============================================
// Synchronised pin vector layout
`define QCTU_NSYNC 8
`define QCTU_S_GATE 4
`define QCTU_S_EXTERNAL_CLOCK_FIVE 6
`define QCTU_S_DEDICATED_TIMER_CLOCK_PIN 7

`endif

// *** logic/qctu_pkg.sv ***
// Types for the quad cascadable timer unit
package qctu_pkg;
  typedef enum logic [1:0] {SRC_CHAIN, SRC_SYS, SRC_DIV16, SRC_PIN} qctu_src_t;
  typedef struct packed {
    logic run;
    logic gateRestart;
    logic gateEn;
    logic outEn;
    logic toggle;
    logic [1:0] capEdge;
    qctu_src_t src;
  } qctu_tcfg_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cap;
    logic match;
    logic outLvl;
  } qctu_tmr_st_t;
endpackage

// *** logic/qctu_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module qctu_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } qctu_sync_st_t;
  qctu_sync_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Take a change only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.o[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pinOut = st_r.o;
endmodule
`default_nettype wire

// *** logic/qctu_timer.sv ***
// One 16-bit timer: count, reference match, output and capture
`timescale 1ns/1ps
`default_nettype none
`include "qctu_params.svh"
module qctu_timer
  import qctu_pkg::*;
#(
  parameter int TW = `QCTU_TW
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic run,
  input wire logic gateBlock,
  input wire logic restart,
  input wire logic capture,
  input wire logic [TW-1:0] refVal,
  input wire logic toggleMode,
  input wire logic outEn,
  output logic [TW-1:0] cnt,
  output logic [TW-1:0] cap,
  output logic match,
  output logic outLvl
);
  qctu_tmr_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.match = 1'b0;
    if (capture) begin
      st_nxt.cap = st_r.cnt;
    end
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (restart) begin
      st_nxt.cnt = '0;
    end else if (tick && !gateBlock) begin
      if (st_r.cnt == refVal) begin
        st_nxt.cnt = '0;
        st_nxt.match = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
    end
    // Pulse idles high; the low pulse lasts one clock
    if (!outEn) begin
      st_nxt.outLvl = 1'b1;
    end else if (st_nxt.match) begin
      st_nxt.outLvl = toggleMode ? !st_r.outLvl : 1'b0;
    end else if (!toggleMode) begin
      st_nxt.outLvl = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{cnt: '0, cap: '0, match: 1'b0, outLvl: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt = st_r.cnt;
  assign cap = st_r.cap;
  assign match = st_r.match;
  assign outLvl = st_r.outLvl;

  AST_MATCH: assert property (@(posedge clk) disable iff (!rst_b)
    run && !restart && tick && !gateBlock && cnt == refVal |=> match && cnt == 16'h0000)
    else $error("match did not fire on reference");
  AST_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    match && !$past(toggleMode) && $past(outEn) |-> !outLvl ##1 (outLvl || match))
    else $error("pulse output wrong");
  AST_TOGGLE: assert property (@(posedge clk) disable iff (!rst_b)
    match && $past(toggleMode) && $past(outEn) |-> outLvl != $past(outLvl))
    else $error("toggle output did not invert");
  AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_b)
    capture |=> cap == $past(cnt))
    else $error("capture lost count");
  AST_GATED: assert property (@(posedge clk) disable iff (!rst_b)
    run && gateBlock && !restart |=> cnt == $past(cnt) && !match)
    else $error("gated timer counted");
  AST_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
    restart |=> cnt == 16'h0000)
    else $error("gate restart did not clear");
endmodule
`default_nettype wire

// *** verif/qctu_pin_model.sv ***
// Behavioural model of the pins that drive the timer unit
`timescale 1ns/1ps
`default_nettype none
module qctu_pin_model (
  input wire logic clk,
  output var logic [7:0] pins
);
  // ==========================================
  // Pin levels
  // Order: inputs 1-4, gate pair one, gate pair two, clock five, dedicated clock
  initial begin
    pins = 8'h30;
  end

  // Every level stands at least two clocks so the synchroniser keeps it
  task automatic setPin(input int idx, input logic lvl);
    @(posedge clk);
    pins[idx] <= lvl;
    repeat (2) @(posedge clk);
  endtask

  // Rising edges only inside a burst; the line rests low afterwards
  task automatic pulses(input int idx, input int n);
    repeat (n) begin
      setPin(idx, 1'b1);
      @(posedge clk);
      setPin(idx, 1'b0);
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking testbench of the quad cascadable timer unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic rst_b;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic [31:0] regRdata;
  logic regWr;
  logic regRd;
  logic [3:0] timerMatchOutput;
  logic siuTimerTick;
  logic irq;
  logic [7:0] pins;
  logic [31:0] d;
  int errCount;
  int nChecks;
  int cycles;
  int lows[4];
  int trans[4];
  int ticks;
  localparam logic [7:0] RA[9] = '{8'h10, 8'h20, 8'h04, 8'h08, 8'h50, 8'h58, 8'h54, 8'hFC, 8'h30};
  localparam logic [31:0] RV[9] = '{32'h1, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  qctu_top i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .timerExtInput1(pins[0]),
    .timerExtInput2(pins[1]),
    .timerExtInput3(pins[2]),
    .timerExtInput4(pins[3]),
    .gateInFirstPair(pins[4]),
    .gateInSecondPair(pins[5]),
    .externalClockFive(pins[6]),
    .dedicatedTimerClockPin(pins[7]),
    .timerMatchOutput(timerMatchOutput),
    .siuTimerTick(siuTimerTick),
    .irq(irq)
  );

  qctu_pin_model i_pins (
    .clk(clk),
    .pins(pins)
  );

  // ==========================================
  // Clock, timeout, verdict
  initial begin
    clk = 1'b0;
  end
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      errCount++;
      endOfTest();
    end
  end

  task automatic endOfTest();
    if (errCount == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================
  // Bus and check tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    v = regRdata;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic cfgAll(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h10 + 4 * i), v);
    end
  endtask

  // Counts low cycles, level changes and interface ticks over n cycles
  task automatic window(input int n);
    logic [3:0] prev;
    ticks = 0;
    for (int i = 0; i < 4; i++) begin
      lows[i] = 0;
      trans[i] = 0;
    end
    @(negedge clk);
    prev = timerMatchOutput;
    repeat (n) begin
      @(negedge clk);
      ticks += (siuTimerTick === 1'b1);
      for (int i = 0; i < 4; i++) begin
        lows[i] += (timerMatchOutput[i] === 1'b0);
        trans[i] += (timerMatchOutput[i] !== prev[i]);
      end
      prev = timerMatchOutput;
    end
  endtask

  task automatic capStep(input logic [31:0] cfg, input logic lvl, input logic [31:0] st,
                         input logic q);
    wr(8'h10, cfg);
    i_pins.setPin(0, lvl);
    waitc(8);
    rd(8'h50, d);
    chk(d, st);
    chk({31'h0, irq}, {31'h0, q});
    wr(8'h54, 32'hFF);
  endtask

  // Gated timers must hold their count, the others keep moving
  task automatic gateStep(input logic g1, input logic g2);
    logic [31:0] v;
    logic [15:0] s[4];
    fork
      i_pins.setPin(4, g1);
      i_pins.setPin(5, g2);
    join
    waitc(8);
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h30 + 4 * i), v);
      s[i] = v[15:0];
    end
    waitc(10);
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h30 + 4 * i), v);
      chk({31'h0, v[15:0] == s[i]}, {31'h0, (i < 2) ? !g1 : !g2});
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk({28'h0, timerMatchOutput}, 32'hF);
    wr(8'h30, 32'h1234);
    for (int i = 0; i < 9; i++) begin
      rd(RA[i], d);
      chk(d, RV[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h20 + 4 * i), 32'h2);
      wr(8'(8'h10 + 4 * i), 32'h121);
    end
    window(30);
    for (int i = 0; i < 4; i++) begin
      chk(lows[i], 10);
    end
    cfgAll(32'h001);
    wr(8'h20, 32'h4);
    wr(8'h10, 32'h131);
    window(50);
    chk(trans[0], 10);
    chk(trans[1], 0);
    wr(8'h10, 32'h001);
    wr(8'h24, 32'h0);
    wr(8'h14, 32'h122);
    wr(8'h28, 32'h0);
    wr(8'h18, 32'h123);
    wr(8'h2C, 32'h1);
    wr(8'h1C, 32'h120);
    fork
      window(160);
      i_pins.pulses(2, 5);
    join
    chk(lows[1], 10);
    chk(lows[2], 5);
    chk(lows[3], 2);
    cfgAll(32'h001);
    wr(8'h20, 32'hFFFF);
    wr(8'h54, 32'hFF);
    wr(8'h58, 32'h10);
    capStep(32'h105, 1'b1, 32'h10, 1'b1);
    capStep(32'h109, 1'b0, 32'h10, 1'b1);
    capStep(32'h109, 1'b1, 32'h0, 1'b0);
    capStep(32'h10D, 1'b0, 32'h10, 1'b1);
    capStep(32'h10D, 1'b1, 32'h10, 1'b1);
    capStep(32'h105, 1'b0, 32'h0, 1'b0);
    wr(8'h58, 32'h0);
    capStep(32'h105, 1'b1, 32'h10, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h20 + 4 * i), 32'hFFFF);
      wr(8'(8'h10 + 4 * i), 32'h141);
    end
    gateStep(1'b0, 1'b1);
    gateStep(1'b1, 1'b0);
    wr(8'h10, 32'h1C1);
    waitc(100);
    rd(8'h30, d);
    chk({31'h0, d[15:0] >= 16'h0064}, 32'h1);
    i_pins.setPin(4, 1'b0);
    i_pins.setPin(4, 1'b1);
    waitc(8);
    rd(8'h30, d);
    chk({31'h0, d[15:0] < 16'h0010}, 32'h1);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h3);
    window(40);
    chk(ticks, 10);
    wr(8'h04, 32'h1);
    fork
      window(80);
      i_pins.pulses(6, 8);
    join
    chk(ticks, 2);
    wr(8'h04, 32'h3);
    fork
      window(80);
      i_pins.pulses(6, 8);
      i_pins.pulses(7, 3);
    join
    chk(ticks, 3);
    endOfTest();
  end
endmodule
`default_nettype wire
